// *** rtl/sdg_pkg.sv ***
// Shared constants for the safety diagnostic block
package sdg_pkg;
    localparam int          SDG_SM_COUNT      = 8;
    localparam int          SDG_SET_W         = 40;
    localparam int          SDG_CHK_W         = 7;
    localparam int          SDG_CW_W          = SDG_SET_W + SDG_CHK_W;
    localparam int          SDG_BRK_W         = 4;
    localparam int          SDG_BRK_LO        = 2;
    localparam int          SDG_DIAG_W        = 8;
    localparam logic [2:0]  SDG_COMM_SAFE     = 3'h0;
    localparam logic [2:0]  SDG_INCR_SAFE     = 3'h7;
    localparam logic [3:0]  SDG_BRK_OFF       = 4'h0;
    localparam logic [11:0] SDG_BRK_RECOMMEND = 12'h400;
    localparam int          SDG_PWM_INIT_CLKS = 12;
    localparam int          SDG_PWM_ERR_CLKS  = 4;
    localparam int          SDG_ZPOSL_DIA2    = 7;
    localparam int          SDG_ECC_SINGLE    = 2;
    localparam int          SDG_ECC_DOUBLE    = 3;
    localparam int          SDG_CRC_BIT       = 5;
    localparam int          SDG_WDOG_BIT      = 6;
    // Diagnostic bit positions
    localparam int          SDG_DIA_OFFSET    = 0;
    localparam int          SDG_DIA_AGC       = 1;
    localparam int          SDG_DIA_ANGLE_VECTOR_ENGINE    = 2;
    localparam int          SDG_DIA_BRKHALL   = 3;
    localparam int          SDG_DIA_ECC       = 4;
    localparam int          SDG_DIA_MAGHALF   = 7;
endpackage

// *** rtl/sdg_sync.sv ***
// Three-stage level synchroniser with agreement filter
`timescale 1ns/10ps
module sdg_sync
    import sdg_pkg::*;
(
    input  wire logic clk,   // Destination clock
    input  wire logic rst,   // Async reset, active high
    input  wire logic din,   // Foreign level
    output logic      dout   // Filtered level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic o;
    } sdg_sync_t;
    sdg_sync_t st_q;
    sdg_sync_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Change counts only once stages two and three agree
        if (st_q.s2 == st_q.s3) begin
            st_d.o = st_q.s3;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.o;
endmodule

// *** rtl/sdg_ecc.sv ***
// SECDED decoder (Hamming plus overall parity) for the settings word
`timescale 1ns/10ps
module sdg_ecc
    import sdg_pkg::*;
(
    input  wire logic [SDG_SET_W-1:0] data_in,   // Stored settings
    input  wire logic [SDG_CHK_W-1:0] chk_in,    // Stored checksum
    output logic      [SDG_SET_W-1:0] data_out,  // Corrected settings
    output logic      [SDG_CHK_W-1:0] chk_calc,  // Checksum of data_in
    output logic                      single_err, // Corrected error
    output logic                      double_err  // Uncorrectable error
);
    // Data bit i sits at codeword position pos(i), skipping powers of two
    function automatic logic [5:0] pos_of(input int i);
        int p;
        int n;
        p = 0;
        n = -1;
        while (n < i) begin
            p = p + 1;
            if ((p & (p - 1)) != 0) begin
                n = n + 1;
            end
        end
        return 6'(p);
    endfunction

    logic [5:0] syn;
    logic [5:0] hcalc;
    logic       par_calc;
    logic       par_mis;

    always_comb begin
        hcalc    = '0;
        par_calc = 1'b0;
        for (int i = 0; i < SDG_SET_W; i++) begin
            if (data_in[i]) begin
                hcalc    = hcalc ^ pos_of(i);
                par_calc = ~par_calc;
            end
        end
        par_calc = par_calc ^ (^hcalc);
        chk_calc = {par_calc, hcalc};
        syn      = hcalc ^ chk_in[5:0];
        par_mis  = (^data_in) ^ (^chk_in);
        data_out = data_in;
        for (int i = 0; i < SDG_SET_W; i++) begin
            if (par_mis && syn == pos_of(i)) begin
                data_out[i] = ~data_in[i];
            end
        end
        single_err = par_mis;
        double_err = !par_mis && (syn != 6'h0);
    end
endmodule

// *** rtl/sdg_diag.sv ***
// Safety diagnostic collector, output safe states and settings protection
`timescale 1ns/10ps
// How it works
// - Eight mechanisms; all except checksum and watchdog land in diag register.
// - Enabled error forces commutation outputs 000 and incremental outputs 111.
// - Offset fault forces safe state only with its enable, shared with broken-Hall, reset zero.
// - Gain-control fault forces safe state only with its enable, reset zero.
// - Broken-Hall fault forces safe state only with its enable, reset zero.
// - Magnitude-half fault forces safe state only with its enable, reset zero.
// - Every returned serial frame carries error and warning flags.
// - Broken-Hall check covers analog chain; inactive while threshold is zero.
// - Four-bit threshold; codes map to 256 through 3840 LSB, zero is off.
// - Settings protected only while corrected enable copy is set; status visible.
// - Settings bit errors show in error flag register bits 2 and 3.
// - Single-bit settings errors are corrected at once, operation unaffected.
// - Double error sets frame error flag; single error sets frame warning.
// - Settings-fault warning and error flags are sticky.
// - Any diagnosed error makes width output show 12 high, error clocks low.
// - Threshold field lives in bits 2 to 5 of outputs-disable register.
// - Bit 7 of zero-position low enables magnitude-half safe states.
module sdg_diag
    import sdg_pkg::*;
(
    input  wire logic                  clk_sys,       // System clock
    input  wire logic                  rst,           // Async reset
    input  wire logic                  clk_link,      // Serial link clock
    input  wire logic                  frame_active_n, // Chip select, low
    input  wire logic [7:0]            disable_reg,   // Outputs/filter disable
    input  wire logic [7:0]            zposl_reg,     // Zero pos low/diag en
    input  wire logic [7:0]            settings1_reg, // Customer settings 1
    input  wire logic [7:0]            settings2_reg, // Customer settings 2
    input  wire logic [7:0]            settings3_reg, // Customer settings 3
    input  wire logic [7:0]            ecc_reg,       // Checksum and enable
    input  wire logic                  fault_offset,  // Offset comp fault
    input  wire logic                  fault_agc,     // Gain control fault
    input  wire logic                  fault_angle_vector_engine,  // Vector overflow
    input  wire logic [11:0]           hall_deviation, // Hall mismatch LSB
    input  wire logic                  fault_mag_half, // Magnitude below half
    input  wire logic                  fault_crc,     // Frame checksum fault
    input  wire logic                  fault_wdog,    // Watchdog fault
    input  wire logic                  status_clear,  // Clear sticky flags
    input  wire logic [2:0]            comm_in,       // Angle commutation
    input  wire logic [2:0]            incr_in,       // Angle incremental
    input  wire logic                  pwm_err_window, // In init/err section
    input  wire logic                  pwm_in,        // Normal width output
    output logic [2:0]                 comm_out,      // Commutation pins
    output logic [2:0]                 incr_out,      // Incremental pins
    output logic                       pwm_out,       // Width output
    output logic [SDG_DIAG_W-1:0]      diag_reg,      // Diagnostic register
    output logic [7:0]                 error_flag_reg, // Error flag register
    output logic                       ecc_status,    // Corrected enable
    output logic [SDG_CHK_W-1:0]       ecc_calc,      // Computed checksum
    output logic [SDG_SET_W-1:0]       settings_eff,  // Corrected settings
    output logic                       frame_error,   // Frame error flag
    output logic                       frame_warning  // Frame warning flag
);
    ////////////////////////////////////////////////////////////////////////
    // Threshold decode
    function automatic logic [11:0] brk_threshold(input logic [3:0] code);
        logic [11:0] t;
        t = 12'h0;
        unique case (code)
            4'h1:    t = 12'h100;
            4'h2:    t = 12'h200;
            4'h3:    t = 12'h300;
            4'h4:    t = 12'h400;
            4'h8:    t = 12'h800;
            4'hf:    t = 12'hf00;
            default: t = {code, 8'h00};
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Settings protection
    logic [SDG_SET_W-1:0] set_raw;
    logic [SDG_SET_W-1:0] set_corr;
    logic [SDG_CHK_W-1:0] chk_calc;
    logic                 e_single;
    logic                 e_double;
    logic                 prot_en;
    logic [3:0]           brk_code;
    logic                 brk_active;
    logic                 brk_fault;

    assign set_raw = {ecc_reg[7], disable_reg, zposl_reg, settings1_reg,
                      settings2_reg, settings3_reg[6:0]};

    sdg_ecc u_ecc (
        .data_in    (set_raw),
        .chk_in     (ecc_reg[SDG_CHK_W-1:0]),
        .data_out   (set_corr),
        .chk_calc   (chk_calc),
        .single_err (e_single),
        .double_err (e_double)
    );

    // Enable taken from the corrected copy so one flip cannot disable it
    assign prot_en    = set_corr[SDG_SET_W-1];
    assign brk_code   = prot_en ? set_corr[31+SDG_BRK_LO+SDG_BRK_W-1 -: SDG_BRK_W]
                                : disable_reg[SDG_BRK_LO+SDG_BRK_W-1:SDG_BRK_LO];
    assign brk_active = (brk_code != SDG_BRK_OFF);
    assign brk_fault  = brk_active &&
                        (hall_deviation >= brk_threshold(brk_code));

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [SDG_DIAG_W-1:0] dia;
        logic                  ecc_single;
        logic                  ecc_double;
        logic                  safe;
        logic                  any_err;
        logic [2:0]            comm;
        logic [2:0]            incr;
        logic                  pwm;
        logic                  ecc_st;
        logic [SDG_CHK_W-1:0]  chk;
        logic [SDG_SET_W-1:0]  seff;
        logic                  flag_tgl;
        logic                  crc_tgl;
    } sdg_diag_t;
    sdg_diag_t st_q;
    sdg_diag_t st_d;

    logic en_offset;
    logic en_agc;
    logic en_brk;
    logic en_mag;
    logic [SDG_DIAG_W-1:0] dia_now;

    always_comb begin
        st_d      = st_q;
        en_offset = zposl_reg[6];
        en_agc    = settings1_reg[6];
        en_brk    = zposl_reg[6];
        en_mag    = zposl_reg[SDG_ZPOSL_DIA2];
        if (prot_en) begin
            en_offset = set_corr[29];
            en_agc    = set_corr[21];
            en_brk    = set_corr[29];
            en_mag    = set_corr[30];
        end
        dia_now                  = '0;
        dia_now[SDG_DIA_OFFSET]  = fault_offset;
        dia_now[SDG_DIA_AGC]     = fault_agc;
        dia_now[SDG_DIA_ANGLE_VECTOR_ENGINE]  = fault_angle_vector_engine;
        dia_now[SDG_DIA_BRKHALL] = brk_fault;
        dia_now[SDG_DIA_ECC]     = prot_en && e_double;
        dia_now[SDG_DIA_MAGHALF] = fault_mag_half;
        st_d.dia = dia_now;
        // Sticky: set beats clear in the same cycle
        st_d.ecc_single = (prot_en && e_single) ||
                          (st_q.ecc_single && !status_clear);
        st_d.ecc_double = (prot_en && e_double) ||
                          (st_q.ecc_double && !status_clear);
        // Checksum and watchdog faults kept off the physical outputs
        st_d.any_err = fault_offset | fault_agc | fault_angle_vector_engine | brk_fault |
                       fault_mag_half | (prot_en && e_double);
        st_d.safe = (fault_offset & en_offset) | (fault_agc & en_agc) |
                    (brk_fault & en_brk) | (fault_mag_half & en_mag) |
                    fault_angle_vector_engine | (prot_en && e_double);
        st_d.comm = st_d.safe ? SDG_COMM_SAFE : comm_in;
        st_d.incr = st_d.safe ? SDG_INCR_SAFE : incr_in;
        // Error frame: init clocks high, error and data clocks low
        st_d.pwm  = st_d.any_err ? pwm_err_window : pwm_in;
        st_d.ecc_st = prot_en;
        st_d.chk  = chk_calc;
        st_d.seff = prot_en ? set_corr : set_raw;
        st_d.crc_tgl = st_q.crc_tgl ^ fault_crc;
        st_d.flag_tgl = st_q.flag_tgl;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link-side frame flags, sampled at frame start
    logic err_lvl;
    logic warn_lvl;
    logic err_sync;
    logic warn_sync;
    logic frame_err_q;
    logic frame_warn_q;
    logic frame_idle;
    logic armed_q;
    logic fault_wdog_q;

    assign err_lvl  = st_q.ecc_double | (|st_q.dia) | fault_wdog_q;
    assign warn_lvl = st_q.ecc_single;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_wdog_q <= 1'b0;
        end else begin
            fault_wdog_q <= fault_wdog;
        end
    end

    sdg_sync u_sync_err (
        .clk  (clk_link),
        .rst  (rst),
        .din  (err_lvl),
        .dout (err_sync)
    );

    sdg_sync u_sync_warn (
        .clk  (clk_link),
        .rst  (rst),
        .din  (warn_lvl),
        .dout (warn_sync)
    );

    // Link clock stops between frames, so rearm from the select level
    assign frame_idle = rst | frame_active_n;

    always_ff @(posedge clk_link or posedge frame_idle) begin
        if (frame_idle) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    // Latched at each frame's first edge so a frame never changes mid-way
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            frame_err_q  <= 1'b0;
            frame_warn_q <= 1'b0;
        end else begin
            if (armed_q) begin
                frame_err_q  <= err_sync;
                frame_warn_q <= warn_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign comm_out       = st_q.comm;
    assign incr_out       = st_q.incr;
    assign pwm_out        = st_q.pwm;
    assign diag_reg       = st_q.dia;
    assign error_flag_reg = {2'b00, 1'b0, 1'b0, st_q.ecc_double,
                             st_q.ecc_single, 2'b00};
    assign ecc_status     = st_q.ecc_st;
    assign ecc_calc       = st_q.chk;
    assign settings_eff   = st_q.seff;
    assign frame_error    = frame_err_q;
    assign frame_warning  = frame_warn_q;
endmodule

// *** verif/sdg_diag_sva.sv ***
// Concurrent checks on the safety diagnostic block ports
`timescale 1ns/10ps
module sdg_diag_sva
    import sdg_pkg::*;
(
    input wire logic                  clk_sys,        // Clock
    input wire logic                  rst,            // Reset
    input wire logic [7:0]            disable_reg,    // Threshold
    input wire logic [7:0]            zposl_reg,      // Enables
    input wire logic [7:0]            settings1_reg,  // Gain enable
    input wire logic [7:0]            ecc_reg,        // Protection
    input wire logic                  fault_offset,   // Fault
    input wire logic                  fault_agc,      // Fault
    input wire logic                  fault_angle_vector_engine,   // Fault
    input wire logic [11:0]           hall_deviation, // Mismatch
    input wire logic                  fault_mag_half, // Fault
    input wire logic                  fault_wdog,     // Fault
    input wire logic                  status_clear,   // Clear
    input wire logic [2:0]            comm_in,        // Angle
    input wire logic [2:0]            incr_in,        // Angle
    input wire logic                  pwm_err_window, // Init part
    input wire logic                  pwm_in,         // Width in
    input wire logic [2:0]            comm_out,       // Pins
    input wire logic [2:0]            incr_out,       // Pins
    input wire logic                  pwm_out,        // Width out
    input wire logic [SDG_DIAG_W-1:0] diag_reg,       // Diag bits
    input wire logic [7:0]            error_flag_reg, // Flags
    input wire logic                  ecc_status      // Enable copy
);
    logic raw;
    logic quiet;
    // Raw enables only mean something while protection is off
    assign raw = !ecc_reg[7] && !ecc_status;
    assign quiet = raw && !fault_angle_vector_engine && !fault_offset && !fault_agc &&
        !fault_mag_half && !fault_wdog && hall_deviation == 12'h000 &&
        !error_flag_reg[SDG_ECC_DOUBLE];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_safe;
        comm_out == SDG_COMM_SAFE && incr_out == SDG_INCR_SAFE;
    endsequence
    sequence s_single;
        error_flag_reg[SDG_ECC_SINGLE] && !status_clear;
    endsequence
    sequence s_double;
        error_flag_reg[SDG_ECC_DOUBLE] && !status_clear;
    endsequence
    chk_safe_gain:
        assert property (raw && fault_agc && settings1_reg[6] |=> s_safe)
        else $error("Gain fault left pins live");
    chk_safe_offset:
        assert property (raw && fault_offset && zposl_reg[6] |=> s_safe)
        else $error("Offset fault left pins live");
    chk_safe_maghalf:
        assert property (raw && fault_mag_half && zposl_reg[7] |=> s_safe)
        else $error("Magnitude fault left pins live");
    chk_pass_quiet:
        assert property (quiet |=> comm_out == $past(comm_in) &&
            incr_out == $past(incr_in) && pwm_out == $past(pwm_in))
        else $error("Outputs not following angle");
    chk_pwm_frame:
        assert property (fault_agc || fault_angle_vector_engine |=>
            pwm_out == $past(pwm_err_window))
        else $error("Width output not in error frame");
    chk_diag_track:
        assert property (1'b1 |=>
            diag_reg[SDG_DIA_OFFSET] == $past(fault_offset) &&
            diag_reg[SDG_DIA_AGC] == $past(fault_agc) &&
            diag_reg[SDG_DIA_ANGLE_VECTOR_ENGINE] == $past(fault_angle_vector_engine) &&
            diag_reg[SDG_DIA_MAGHALF] == $past(fault_mag_half))
        else $error("Diag bits off their faults");
    chk_brk_off:
        assert property (raw && disable_reg[5:2] == SDG_BRK_OFF |=>
            !diag_reg[SDG_DIA_BRKHALL])
        else $error("Hall check active while off");
    chk_brk_trip:
        assert property (raw && disable_reg[5:2] != SDG_BRK_OFF &&
            hall_deviation >= {disable_reg[5:2], 8'h00} |=>
            diag_reg[SDG_DIA_BRKHALL])
        else $error("Hall check missed deviation");
    chk_single_kept:
        assert property (s_single |=> error_flag_reg[SDG_ECC_SINGLE])
        else $error("Single flag dropped");
    chk_double_kept:
        assert property (s_double |=> error_flag_reg[SDG_ECC_DOUBLE])
        else $error("Double flag dropped");
    chk_off_silent:
        assert property (raw && error_flag_reg[3:2] == 2'b00 |=>
            error_flag_reg[3:2] == 2'b00)
        else $error("Flag raised with protection off");
endmodule

bind sdg_diag sdg_diag_sva u_sva (.clk_sys(clk_sys), .rst(rst),
    .disable_reg(disable_reg), .zposl_reg(zposl_reg),
    .settings1_reg(settings1_reg), .ecc_reg(ecc_reg),
    .fault_offset(fault_offset), .fault_agc(fault_agc),
    .fault_angle_vector_engine(fault_angle_vector_engine), .hall_deviation(hall_deviation),
    .fault_mag_half(fault_mag_half), .fault_wdog(fault_wdog),
    .status_clear(status_clear), .comm_in(comm_in), .incr_in(incr_in),
    .pwm_err_window(pwm_err_window), .pwm_in(pwm_in),
    .comm_out(comm_out), .incr_out(incr_out), .pwm_out(pwm_out),
    .diag_reg(diag_reg), .error_flag_reg(error_flag_reg),
    .ecc_status(ecc_status));

// *** verif/sdg_host_model.sv ***
// Host side of the serial link: frames and flag capture
`timescale 1ns/10ps
module sdg_host_model (
    output logic      clk_link,       // Link clock
    output logic      frame_active_n, // Select, low
    input  wire logic frame_error,    // Returned error
    input  wire logic frame_warning,  // Returned warning
    output logic      seen_error,     // Captured error
    output logic      seen_warning    // Captured warning
);
    initial begin
        clk_link = 1'b0;
        frame_active_n = 1'b1;
        seen_error = 1'b0;
        seen_warning = 1'b0;
    end
    // Clock stands still between frames, as a real host does
    task automatic frame();
        frame_active_n = 1'b0;
        #37;
        repeat (16) begin
            clk_link = 1'b1;
            #40;
            clk_link = 1'b0;
            #40;
        end
        seen_error = frame_error;
        seen_warning = frame_warning;
        #40;
        frame_active_n = 1'b1;
        #200;
    endtask
endmodule

// *** verif/sdg_diag_test.sv ***
// Self-checking bench for the safety diagnostic block
`timescale 1ns/10ps
module sdg_diag_test;
    import sdg_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        clk_link, frame_active_n, f_off, f_agc, f_cor, f_mag;
    logic        f_crc, f_wd, clr, win, pwm, pwm_o, ecc_st, f_err, f_warn;
    logic        h_err, h_warn;
    logic [7:0]  dis, zp, s1, s2, s3, ecc, diag, eflag;
    logic [11:0] dev;
    logic [2:0]  cin, iin, comm, incr;
    logic [6:0]  calc;
    logic [39:0] eff, gold;
    logic [3:0]  codes[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hf};
    int          pos[5] = '{0, 1, 7, 3, 2};
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    always #10 clk_sys = ~clk_sys;
    sdg_diag dut (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
        .frame_active_n(frame_active_n), .disable_reg(dis), .zposl_reg(zp),
        .settings1_reg(s1), .settings2_reg(s2), .settings3_reg(s3),
        .ecc_reg(ecc), .fault_offset(f_off), .fault_agc(f_agc),
        .fault_angle_vector_engine(f_cor), .hall_deviation(dev), .fault_mag_half(f_mag),
        .fault_crc(f_crc), .fault_wdog(f_wd), .status_clear(clr),
        .comm_in(cin), .incr_in(iin), .pwm_err_window(win), .pwm_in(pwm),
        .comm_out(comm), .incr_out(incr), .pwm_out(pwm_o), .diag_reg(diag),
        .error_flag_reg(eflag), .ecc_status(ecc_st), .ecc_calc(calc),
        .settings_eff(eff), .frame_error(f_err), .frame_warning(f_warn));
    sdg_host_model host (.clk_link(clk_link), .frame_active_n(frame_active_n),
        .frame_error(f_err), .frame_warning(f_warn), .seen_error(h_err),
        .seen_warning(h_warn));
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic cmp_reg(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pins(input logic [6:0] got, input logic [6:0] exp);
        cmp_reg(40'(got), 40'(exp));
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Second frame sees flags that settled during the first
    task automatic frames();
        host.frame();
        host.frame();
        step(1);
    endtask
    function automatic logic [6:0] want(input logic safe, input logic err);
        want[6] = err ? win : pwm;
        want[5:0] = safe ? {SDG_COMM_SAFE, SDG_INCR_SAFE} : {cin, iin};
    endfunction
    function automatic logic [39:0] word();
        return {ecc[7], dis, zp, s1, s2, s3[6:0]};
    endfunction
    task automatic jiggle();
        cin = 3'($urandom);
        iin = 3'($urandom);
        win = 1'($urandom);
        pwm = 1'($urandom);
        f_crc = 1'($urandom);
        {zp, s1, s2, s3} = $urandom;
    endtask
    initial begin
        void'($urandom(32'hf7a90afd));
        {dis, zp, s1, s2, s3, ecc, dev, cin, iin} = '0;
        {f_off, f_agc, f_cor, f_mag, f_crc, f_wd, clr, win, pwm} = '0;
        host.frame();
        step(12);
        rst = 1'b0;
        step(1);
        cmp_reg(40'({diag, eflag, ecc_st}), 40'h0);
        dis = 8'h10;
        repeat (40) begin
            jiggle();
            step(1);
            cmp_pins({pwm_o, comm, incr}, want(1'b0, 1'b0));
        end
        for (int m = 0; m < 5; m++) begin
            for (int e = 0; e < 2; e++) begin
                jiggle();
                zp[6] = e && (m == 0 || m == 3);
                zp[7] = e && m == 2;
                s1[6] = e && m == 1;
                f_off = (m == 0);
                f_agc = (m == 1);
                f_mag = (m == 2);
                f_cor = (m == 4);
                dev = (m == 3) ? 12'h410 : 12'h000;
                step(2);
                cmp_pins({pwm_o, comm, incr}, want(e || m == 4, 1'b1));
                cmp_reg(40'(diag), 40'(8'h01 << pos[m]));
            end
        end
        {f_off, f_agc, f_mag, f_cor} = '0;
        foreach (codes[k]) begin
            for (int d = 0; d < 2; d++) begin
                dis[5:2] = codes[k];
                dev = {codes[k], 8'h00} + (d ? 12'h010 : 12'hff0);
                step(2);
                cmp_reg(40'(diag[3]), 40'(d && codes[k] != 4'h0));
            end
        end
        dis[5:2] = 4'h4;
        dev = 12'h000;
        for (int w = 0; w < 3; w++) begin
            f_agc = (w == 0);
            f_wd = (w == 1);
            frames();
            cmp_reg(40'({h_err, h_warn}), 40'({w < 2, 1'b0}));
        end
        s2 ^= 8'h01;
        step(2);
        cmp_reg(40'(eflag[3:2]), 40'h0);
        ecc = 8'h80;
        step(3);
        ecc = {1'b1, calc};
        gold = word();
        step(2);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
        cmp_reg(eff, gold);
        cmp_reg(40'({ecc_st, eflag[3:2]}), 40'h4);
        s2 ^= 8'h04;
        frames();
        cmp_reg(eff, gold);
        cmp_reg(40'({eflag[3:2], h_err, h_warn}), 40'h5);
        s2 ^= 8'h04;
        step(3);
        cmp_reg(40'(eflag[3:2]), 40'h1);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
        cmp_reg(40'(eflag[3:2]), 40'h0);
        s2 ^= 8'h0c;
        frames();
        cmp_reg(40'({eflag[3:2], h_err}), 40'h5);
        cmp_pins({pwm_o, comm, incr}, want(1'b1, 1'b1));
        give_verdict();
    end
endmodule
